// ==== logic/t8_edge_sync.sv ====
// two-flop synchroniser with rising and falling edge pulses
// assumes din is asynchronous to pclk
`timescale 1ns/1ps
`default_nettype none
module t8_edge_sync (
    // clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // pin and edges
    input  wire logic din,
    output logic      rise,
    output logic      fall
);
    logic s1_r;
    logic s2_r;
    logic s3_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
            s3_r <= 1'b0;
        end else begin
            s1_r <= din;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rise <= 1'b0;
            fall <= 1'b0;
        end else begin
            rise <= s2_r & ~s3_r;
            fall <= ~s2_r & s3_r;
        end
    end

    AST_ONE_PULSE_PER_EDGE: assert property (@(posedge pclk) disable iff (!presetn)
        (rise || fall) |=> !(rise || fall))
        else $error("edge pulse lasted more than one cycle");
endmodule // t8_edge_sync
`default_nettype wire

// ==== logic/t8_prescaler.sv ====
// free-running divider of the main clock, one tick per tap period
// assumes pclk is the main system clock
`timescale 1ns/1ps
`default_nettype none
module t8_prescaler #(
    parameter int unsigned DIV_W = t8_pkg::DIV_W
) (
    // clock and reset
    input  wire logic             pclk,
    input  wire logic             presetn,
    // tick bus
    output logic [DIV_W-1:0]      tick
);
    logic [DIV_W-1:0] div_r;
    logic [DIV_W-1:0] hit;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_r <= '0;
        end else begin
            div_r <= div_r + {{(DIV_W-1){1'b0}}, 1'b1};
        end
    end

    for (genvar i = 0; i < DIV_W; i++) begin : g_tap
        assign hit[i] = &div_r[i:0];
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick <= '0;
        end else begin
            tick <= hit;
        end
    end
endmodule // t8_prescaler
`default_nettype wire

// ==== logic/t8_timer_top.sv ====
// three 8-bit timer/event counters with compare, PWM and timer outputs
// assumes an APB master on pclk; event and subsystem clock pins are asynchronous
//
// The APB register port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module t8_timer_top #(
    parameter int unsigned ADDR_W = t8_pkg::ADDR_W
) (
    // clock and reset
    input  wire logic              pclk,
    input  wire logic              presetn,
    // apb slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    input  wire logic [3:0]        pstrb,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    // count sources
    input  wire logic              event_input_0,
    input  wire logic              event_input_1,
    input  wire logic              subsystem_clk,
    // timer outputs and interrupts
    output logic                   unit0_timer_out,
    output logic                   unit1_timer_out,
    output logic                   unit2_timer_out,
    output logic [2:0]             timer_out_drive_en,
    output logic [2:0]             match_irq
);
    localparam int unsigned NU = t8_pkg::NUM_UNITS;

    t8_pkg::t8_mode_t       mode_r [NU];
    logic [7:0]             cmp_r  [NU];
    logic [7:0]             cnt_r  [NU];
    logic [NU-1:0]          tout_r;
    logic [NU-1:0]          ten_r;
    logic [NU-1:0]          irq_r;
    logic [NU-1:0]          tick;
    logic [NU-1:0]          match;
    logic [t8_pkg::DIV_W-1:0] pre_tick;
    logic [NU-1:0]          ev_rise;
    logic [NU-1:0]          ev_fall;

    logic [31:0]            prdata_r;
    logic                   pready_r;
    logic                   pslverr_r;
    logic [NU-1:0]          hit_mode;
    logic [NU-1:0]          hit_cmp;
    logic [NU-1:0]          hit_cnt;
    logic                   mapped;
    logic [t8_pkg::IDX_W-1:0] idx;
    logic                   setup;
    logic                   wr_en;
    logic [7:0]             rd_val;

    // count sources
    t8_prescaler #(
        .DIV_W (t8_pkg::DIV_W)
    ) u_pre (
        .pclk    (pclk),
        .presetn (presetn),
        .tick    (pre_tick)
    );

    t8_edge_sync u_ev0 (
        .pclk    (pclk),
        .presetn (presetn),
        .din     (event_input_0),
        .rise    (ev_rise[0]),
        .fall    (ev_fall[0])
    );

    t8_edge_sync u_ev1 (
        .pclk    (pclk),
        .presetn (presetn),
        .din     (event_input_1),
        .rise    (ev_rise[1]),
        .fall    (ev_fall[1])
    );

    // subsystem clock is sampled; each rising edge is one count
    t8_edge_sync u_sub (
        .pclk    (pclk),
        .presetn (presetn),
        .din     (subsystem_clk),
        .rise    (ev_rise[2]),
        .fall    (ev_fall[2])
    );

    function automatic logic pick_src(
        input t8_pkg::t8_clksel_t sel,
        input logic               a,
        input logic               b,
        input logic               c,
        input logic               d
    );
        logic r;
        r = 1'b0;
        unique case (sel)
            t8_pkg::CS_SRC_A:    r = a;
            t8_pkg::CS_SRC_B:    r = b;
            t8_pkg::CS_EXT_RISE: r = c;
            t8_pkg::CS_EXT_FALL: r = d;
        endcase
        return r;
    endfunction

    // per-unit count enable
    always_comb begin
        tick[0] = pick_src(mode_r[0].clksel, 1'b1, pre_tick[t8_pkg::TAP_DIV8],
                           ev_rise[0], ev_fall[0]);
        tick[1] = pick_src(mode_r[1].clksel, pre_tick[t8_pkg::TAP_DIV16],
                           pre_tick[t8_pkg::TAP_DIV256], ev_rise[1], ev_fall[1]);
        // prohibited code counts nothing
        tick[2] = pick_src(mode_r[2].clksel, pre_tick[t8_pkg::TAP_DIV32],
                           pre_tick[t8_pkg::TAP_DIV128], ev_rise[2], 1'b0);
    end

    // address decode
    always_comb begin
        idx    = paddr[ADDR_W-1:2];
        mapped = 1'b0;
        for (int i = 0; i < NU; i++) begin
            hit_mode[i] = (paddr[1:0] == 2'h0) && (idx == t8_pkg::IDX_MODE[i]);
            hit_cmp[i]  = (paddr[1:0] == 2'h0) && (idx == t8_pkg::IDX_CMP[i]);
            hit_cnt[i]  = (paddr[1:0] == 2'h0) && (idx == t8_pkg::IDX_CNT[i]);
            mapped      = mapped | hit_mode[i] | hit_cmp[i] | hit_cnt[i];
        end
    end

    assign setup = psel & ~penable;
    assign wr_en = psel & penable & pready_r & pwrite & pstrb[0];

    always_comb begin
        rd_val = 8'h00;
        for (int i = 0; i < NU; i++) begin
            if (hit_mode[i]) begin
                rd_val = mode_r[i];
            end
            if (hit_cmp[i]) begin
                rd_val = cmp_r[i];
            end
            if (hit_cnt[i]) begin
                rd_val = cnt_r[i];
            end
        end
    end

    // bus answer: zero wait, read data captured in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r <= 1'b0;
        end else begin
            pready_r <= 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r  <= 32'h0000_0000;
            pslverr_r <= 1'b0;
        end else if (setup) begin
            prdata_r  <= {24'h00_0000, rd_val};
            pslverr_r <= ~mapped;
        end
    end

    // mode control registers and compare registers
    for (genvar u = 0; u < NU; u++) begin : g_reg
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                mode_r[u] <= t8_pkg::t8_mode_t'(t8_pkg::MODE_RST);
            end else if (wr_en && hit_mode[u]) begin
                mode_r[u] <= t8_pkg::t8_mode_t'(pwdata[7:0] & t8_pkg::MODE_WMASK);
            end
        end

        // no reset: contents are undefined until software writes them
        always_ff @(posedge pclk) begin
            if (wr_en && hit_cmp[u]) begin
                cmp_r[u] <= pwdata[7:0];
            end
        end
    end

    // counters, match interrupts and timer outputs
    for (genvar u = 0; u < NU; u++) begin : g_unit
        assign match[u] = (cnt_r[u] == cmp_r[u]);

        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                cnt_r[u] <= t8_pkg::CNT_RST;
            end else if (!mode_r[u].count_run_enable) begin
                cnt_r[u] <= t8_pkg::CNT_RST;
            end else if (tick[u]) begin
                if (match[u] && !mode_r[u].pwm_mode_select) begin
                    cnt_r[u] <= t8_pkg::CNT_RST;
                end else begin
                    cnt_r[u] <= cnt_r[u] + 8'h01;
                end
            end
        end

        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                irq_r[u] <= 1'b0;
            end else begin
                irq_r[u] <= mode_r[u].count_run_enable & tick[u] & match[u];
            end
        end

        // timer mode toggles on each match, PWM is high while count below compare
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                tout_r[u] <= 1'b0;
            end else if (!mode_r[u].count_run_enable) begin
                tout_r[u] <= 1'b0;
            end else if (mode_r[u].pwm_mode_select) begin
                tout_r[u] <= (cnt_r[u] < cmp_r[u]);
            end else if (tick[u] && match[u]) begin
                tout_r[u] <= ~tout_r[u];
            end
        end

        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                ten_r[u] <= 1'b0;
            end else begin
                ten_r[u] <= mode_r[u].timer_output_enable;
            end
        end
    end

    assign prdata             = prdata_r;
    assign pready             = pready_r;
    assign pslverr            = pslverr_r;
    assign unit0_timer_out    = tout_r[0];
    assign unit1_timer_out    = tout_r[1];
    assign unit2_timer_out    = tout_r[2];
    assign timer_out_drive_en = ten_r;
    assign match_irq          = irq_r;

    // checks
    AST_HOLD_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
        !mode_r[0].count_run_enable |=> cnt_r[0] == 8'h00)
        else $error("stopped counter not held at zero");

    AST_WRAP_ON_MATCH: assert property (@(posedge pclk) disable iff (!presetn)
        mode_r[1].count_run_enable && !mode_r[1].pwm_mode_select && tick[1] && match[1]
        |=> cnt_r[1] == 8'h00 && match_irq[1])
        else $error("counter did not clear with interrupt on match");

    AST_COUNT_UP: assert property (@(posedge pclk) disable iff (!presetn)
        mode_r[0].count_run_enable && $stable(mode_r[0]) && tick[0] && !match[0]
        |=> cnt_r[0] == $past(cnt_r[0]) + 8'h01)
        else $error("counter did not advance on its tick");

    AST_IRQ_CAUSE: assert property (@(posedge pclk) disable iff (!presetn)
        match_irq[2] |-> $past(match[2] && tick[2] && mode_r[2].count_run_enable))
        else $error("match interrupt without a match");

    AST_DIV8_SPACING: assert property (@(posedge pclk) disable iff (!presetn)
        pre_tick[t8_pkg::TAP_DIV8] |=> !pre_tick[t8_pkg::TAP_DIV8] [*7]
        ##1 pre_tick[t8_pkg::TAP_DIV8])
        else $error("divide-by-8 tick spacing wrong");

    AST_PROHIBITED_IDLE: assert property (@(posedge pclk) disable iff (!presetn)
        mode_r[2].clksel == t8_pkg::CS_EXT_FALL |-> !tick[2])
        else $error("unit 2 counted on the prohibited source");

    AST_RSVD_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
        wr_en && hit_mode[1] |=> mode_r[1].rsvd == 3'h0
        && mode_r[1].count_run_enable == $past(pwdata[7]))
        else $error("mode register reserved bits not zero or run bit lost");

    AST_CMP_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
        wr_en && hit_cmp[0] |=> cmp_r[0] == $past(pwdata[7:0]))
        else $error("compare write not stored");

    AST_OUT_ENABLE: assert property (@(posedge pclk) disable iff (!presetn)
        wr_en && hit_mode[2] ##1 1'b1 |=> timer_out_drive_en[2] == $past(pwdata[0], 2))
        else $error("timer output enable did not follow its bit");

    AST_UNMAPPED_ERR: assert property (@(posedge pclk) disable iff (!presetn)
        setup && !mapped |=> pslverr && prdata == 32'h0000_0000)
        else $error("unmapped access not answered with error");

    AST_RESET_STOPPED: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(presetn) |-> mode_r[0] == t8_pkg::MODE_RST && !tout_r[0])
        else $error("unit not stopped after reset");
endmodule // t8_timer_top
`default_nettype wire

// ==== shared/t8_pkg.sv ====
// constants and types for the triple 8-bit timer/event counter
// assumes one 200 MHz clock and an APB slave port in front of the registers
// Summary of operation
// - three independent 8-bit counters, each with compare register and timer output
// - counter equal to compare raises that unit's match interrupt pulse
// - in timer mode counter returns to zero on match, period is compare plus one ticks; in PWM mode it wraps past FF
// - compare register accepts any byte value from 00 to FF
// - compare register has no defined value after reset
// - counter is readable as a byte and reset clears it
// - run bit 7 gates counting; cleared holds the counter at zero
// - bit 6 selects plain timer mode or PWM output mode
// - unit 0 counts fx, fx/8, rising or falling event input 0
// - unit 1 counts fx/16, fx/256, rising or falling event input 1
// - unit 2 counts fx/32, fx/128 or subsystem clock; code 11 prohibited
// - bit 0 hands the output pin to the timer, else port control
// - mode register written as a byte, reset clears it to zero
`default_nettype none
package t8_pkg;
    localparam int unsigned NUM_UNITS = 3;
    localparam int unsigned CNT_W     = 8;
    localparam int unsigned ADDR_W    = 18;
    localparam int unsigned IDX_W     = 16;
    localparam int unsigned DIV_W     = 8;

    // register indices, byte address is four times the index
    localparam logic [2:0][15:0] IDX_MODE = {16'hFF5B, 16'hFF57, 16'hFF53};
    localparam logic [2:0][15:0] IDX_CMP  = {16'hFF58, 16'hFF54, 16'hFF50};
    localparam logic [2:0][15:0] IDX_CNT  = {16'hFF59, 16'hFF55, 16'hFF51};

    // field positions of the mode control byte
    localparam int unsigned MODE_RUN_BIT = 7;
    localparam int unsigned MODE_PWM_BIT = 6;
    localparam int unsigned MODE_SEL_LSB = 1;
    localparam int unsigned MODE_OE_BIT  = 0;
    localparam logic [7:0]  MODE_RST     = 8'h00;
    localparam logic [7:0]  MODE_WMASK   = 8'hC7;
    localparam logic [7:0]  CNT_RST      = 8'h00;

    // prescaler taps: tap i ticks once every 2^(i+1) clocks
    localparam int unsigned TAP_DIV8   = 2;
    localparam int unsigned TAP_DIV16  = 3;
    localparam int unsigned TAP_DIV32  = 4;
    localparam int unsigned TAP_DIV128 = 6;
    localparam int unsigned TAP_DIV256 = 7;

    typedef enum logic [1:0] {
        CS_SRC_A    = 2'b00,
        CS_SRC_B    = 2'b01,
        CS_EXT_RISE = 2'b10,
        CS_EXT_FALL = 2'b11
    } t8_clksel_t;

    typedef struct packed {
        logic       count_run_enable;
        logic       pwm_mode_select;
        logic [2:0] rsvd;
        t8_clksel_t clksel;
        logic       timer_output_enable;
    } t8_mode_t;
endpackage
`default_nettype wire

// ==== test/tb_t8_timer_top.sv ====
// self-checking bench for the triple 8-bit timer/event counter
// assumes the apb slave answers with pready high from the first edge after reset
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin num_checks++; if ((got) !== (exp)) begin error_cnt++; \
    $display("wrong value %s expected %0h seen %0h", nm, exp, got); end end
module tb_t8_timer_top;
    typedef struct packed { logic wr; logic err; logic [7:0] dat; } t8_note_t;
    localparam int LIMIT = 60000;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [17:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0]  pstrb, strb;
    logic        event_input_0, event_input_1, subsystem_clk;
    logic        unit0_timer_out, unit1_timer_out, unit2_timer_out;
    logic [2:0]  drv_en, match_irq;
    wire  [2:0]  tout = {unit2_timer_out, unit1_timer_out, unit0_timer_out};
    int          error_cnt, num_checks, cyc, seed;
    t8_note_t    notes[$];
    t8_note_t    note;

    t8_timer_top i_t8_timer_top (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .event_input_0(event_input_0),
        .event_input_1(event_input_1), .subsystem_clk(subsystem_clk),
        .unit0_timer_out(unit0_timer_out), .unit1_timer_out(unit1_timer_out),
        .unit2_timer_out(unit2_timer_out), .timer_out_drive_en(drv_en),
        .match_irq(match_irq));

    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    task automatic stop_test;
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    always @(posedge pclk) begin
        cyc++;
        if (cyc == LIMIT) begin
            error_cnt++;
            stop_test();
        end
    end

    // compares each completed access with the oldest note
    always @(posedge pclk) begin
        if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
            if (notes.size() == 0) begin
                error_cnt++;
                $display("wrong value note queue expected 1 seen 0");
            end else begin
                note = notes.pop_front();
                `CHK("pslverr", note.err, pslverr)
                if (!note.wr) `CHK("prdata", {24'h0, note.dat}, prdata)
            end
        end
    end

    task automatic apb(input logic wr, input logic [15:0] idx, input logic [7:0] wd,
                       input logic [7:0] exp, input logic err);
        notes.push_back({wr, err, exp});
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= {idx, 2'b00};
        pwdata  <= {24'h0, wd};
        pstrb   <= strb;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [15:0] idx, input logic [7:0] d);
        apb(1'b1, idx, d, 8'h00, 1'b0);
    endtask

    task automatic rd(input logic [15:0] idx, input logic [7:0] exp);
        apb(1'b0, idx, 8'h00, exp, 1'b0);
    endtask

    task automatic tick;
        @(posedge pclk);
        #1;
    endtask

    task automatic setup(input int n, input logic [7:0] m, input logic [7:0] c);
        wr(t8_pkg::IDX_MODE[n], 8'h00);
        wr(t8_pkg::IDX_CMP[n], c);
        wr(t8_pkg::IDX_MODE[n], m);
        wr(t8_pkg::IDX_MODE[n], m | 8'h80);
        repeat (3) tick();
        `CHK("drive enable", m[0], drv_en[n])
    endtask

    task automatic wait_irq(input int n);
        int i;
        i = 0;
        tick();
        while (match_irq[n] !== 1'b1 && i < 4000) begin
            tick();
            i++;
        end
    endtask

    task automatic measure(input int n, input int per, input bit tgl);
        int   t0;
        logic o0;
        wait_irq(n);
        t0 = cyc;
        o0 = tout[n];
        wait_irq(n);
        `CHK("irq period", per, cyc - t0)
        if (tgl) `CHK("timer out", ~o0, tout[n])
    endtask

    task automatic pin(input int n, input logic v);
        @(posedge pclk);
        if (n == 0) event_input_0 <= v;
        else event_input_1 <= v;
        repeat (3) @(posedge pclk);
    endtask

    initial begin
        int         p, hi;
        logic [7:0] v, c;
        int         divs[3][2] = '{'{1, 8}, '{16, 256}, '{32, 128}};
        {presetn, psel, penable, pwrite, paddr, pwdata, subsystem_clk} = '0;
        {event_input_0, event_input_1} = 2'b00;
        pstrb = 4'hF;
        strb  = 4'hF;
        seed  = $urandom(11);
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        for (int n = 0; n < 3; n++) begin
            rd(t8_pkg::IDX_MODE[n], 8'h00);
            rd(t8_pkg::IDX_CNT[n], 8'h00);
        end
        apb(1'b1, 16'h0000, 8'h12, 8'h00, 1'b1);
        apb(1'b0, 16'h0000, 8'h00, 8'h00, 1'b1);
        wr(t8_pkg::IDX_CNT[0], 8'h5A);
        rd(t8_pkg::IDX_CNT[0], 8'h00);
        $display("test reset done");
        for (int n = 0; n < 3; n++) begin
            v = 8'($urandom) & 8'h7F;
            if (n == 2 && v[2:1] == 2'b11) v[2] = 1'b0;
            wr(t8_pkg::IDX_MODE[n], v);
            rd(t8_pkg::IDX_MODE[n], v & t8_pkg::MODE_WMASK);
            repeat (3) tick();
            `CHK("drive enable", v[0], drv_en[n])
            wr(t8_pkg::IDX_MODE[n], 8'h00);
            for (int k = 0; k < 3; k++) begin
                c = (k == 0) ? 8'h00 : (k == 1) ? 8'hFF : 8'($urandom);
                wr(t8_pkg::IDX_CMP[n], c);
                rd(t8_pkg::IDX_CMP[n], c);
            end
        end
        strb = 4'hE;
        wr(t8_pkg::IDX_CMP[2], 8'h33);
        strb = 4'hF;
        rd(t8_pkg::IDX_CMP[2], c);
        $display("test registers done");
        for (int n = 0; n < 3; n++) begin
            for (int s = 0; s < 2; s++) begin
                c = 8'($urandom % 5);
                setup(n, {6'b0, s[0], 1'b1}, c);
                measure(n, (c + 1) * divs[n][s], 1'b1);
                wr(t8_pkg::IDX_MODE[n], 8'h00);
                repeat (2) tick();
                rd(t8_pkg::IDX_CNT[n], 8'h00);
            end
        end
        $display("test interval done");
        for (int n = 0; n < 2; n++) begin
            for (int e = 0; e < 2; e++) begin
                p = 2 + $urandom % 5;
                setup(n, {5'b0, 1'b1, e[0], 1'b0}, 8'hFF);
                for (int k = 0; k < p; k++) begin
                    pin(n, 1'b1);
                    if (k < p - 1) pin(n, 1'b0);
                end
                repeat (8) tick();
                rd(t8_pkg::IDX_CNT[n], 8'(e ? p - 1 : p));
                wr(t8_pkg::IDX_MODE[n], 8'h00);
                pin(n, 1'b0);
            end
        end
        p = 2 + $urandom % 5;
        setup(2, 8'h04, 8'hFF);
        for (int k = 0; k < 2 * p; k++) begin
            @(posedge pclk);
            subsystem_clk <= ~subsystem_clk;
            repeat (9) @(posedge pclk);
        end
        repeat (8) tick();
        rd(t8_pkg::IDX_CNT[2], 8'(p));
        wr(t8_pkg::IDX_MODE[2], 8'h00);
        $display("test events done");
        c = 8'(1 + $urandom % 254);
        setup(0, 8'h41, c);
        measure(0, 256, 1'b0);
        hi = 0;
        repeat (256) begin
            tick();
            if (tout[0] === 1'b1) hi++;
        end
        `CHK("pwm duty", int'(c), hi)
        wr(t8_pkg::IDX_MODE[0], 8'h00);
        $display("test pwm done");
        stop_test();
    end
endmodule // tb_t8_timer_top
`default_nettype wire
